// ### hdl/aptr_regs.sv
/*
 * APB register bank for fixed test pattern, offset calibration
 * reference selection and reference buffer margining.
 * Assumes an APB master on core_clk_i; conversion result is synchronous.
 */
//
// Contract
// - Pattern top register holds four pattern MSBs in bits 3:0, resets zero.
// - Top bits reach the output only while pattern output select is one.
// - Pattern top register bits 7:4 read zero.
// - Reference select decodes six voltages; codes 6 and 7 mean 5.0 V.
// - Offset calibration register bits 7:3 read zero.
// - Margining register bit 5 enables margining, resets zero.
// - Five-bit trim code is signed: upper half negative steps.
// - Margining register bits 7:6 read zero.
// - Output bits 21:4 carry result or pattern per select.
// - Middle pattern byte lives in its own read/write register.
`timescale 1ns/1ps
module aptr_regs
   import aptr_pkg::*;
(
   // Clock and reset
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_i,
   // APB slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [ADDR_W-1:0]        paddr,
   input  wire logic [31:0]              pwdata,
   input  wire logic [3:0]               pstrb,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // Converter side
   input  wire logic [PAT_W-1:0]         conv_result_i,
   output logic      [WORD_W-1:0]        out_word_o,
   output aptr_ref_t                     cal_reference_o,
   output logic                          margining_enable_o,
   output logic signed [TRIM_W-1:0]      margining_trim_steps_o
);

   // ***************************************************************
   // Storage
   // ***************************************************************
   logic [TOP_W-1:0]   pattern_top_nibble_ff;
   logic [7:0]         pattern_middle_byte_ff;
   logic [7:0]         pattern_low_byte_ff;
   logic               pattern_output_select_ff;
   logic [CAL_W-1:0]   cal_sel_ff;
   logic               margining_enable_ff;
   logic [TRIM_W-1:0]  margining_trim_code_ff;
   logic [PAT_W-1:0]   pattern;
   logic [7:0]         idx;
   logic               wr_en;
   logic               rd_en;
   logic               hit;
   logic [7:0]         rd_byte;

   assign idx   = paddr[BYTE_SHIFT +: 8];
   assign wr_en = psel & penable & pwrite & pstrb[0];
   assign rd_en = psel & penable & ~pwrite;

   function automatic logic mapped(input logic [7:0] i);
      return (i == IDX_PATN_LOW) || (i == IDX_PATN_MID) || (i == IDX_PATN_TOP) ||
             (i == IDX_CAL_REF) || (i == IDX_REF_MARGIN) || (i == IDX_DATA_CTRL);
   endfunction

   // Unaligned or unmapped accesses fail with pslverr
   assign hit = mapped(idx) && (paddr[BYTE_SHIFT-1:0] == 2'b00) &&
                (paddr[ADDR_W-1:BYTE_SHIFT+8] == '0);

   // ***************************************************************
   // Register writes
   // ***************************************************************
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pattern_top_nibble_ff <= RST_TOP;
      end else if (wr_en && hit && idx == IDX_PATN_TOP) begin
         pattern_top_nibble_ff <= pwdata[TOP_W-1:0];
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pattern_middle_byte_ff <= RST_BYTE;
         pattern_low_byte_ff    <= RST_BYTE;
      end else if (wr_en && hit) begin
         if (idx == IDX_PATN_MID) begin
            pattern_middle_byte_ff <= pwdata[7:0];
         end
         if (idx == IDX_PATN_LOW) begin
            pattern_low_byte_ff <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pattern_output_select_ff <= 1'b0;
      end else if (wr_en && hit && idx == IDX_DATA_CTRL) begin
         pattern_output_select_ff <= pwdata[PSEL_BIT];
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cal_sel_ff <= RST_CAL;
      end else if (wr_en && hit && idx == IDX_CAL_REF) begin
         cal_sel_ff <= pwdata[CAL_W-1:0];
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         margining_enable_ff    <= 1'b0;
         margining_trim_code_ff <= RST_TRIM;
      end else if (wr_en && hit && idx == IDX_REF_MARGIN) begin
         margining_enable_ff    <= pwdata[MARG_EN_BIT];
         margining_trim_code_ff <= pwdata[TRIM_W-1:0];
      end
   end

   // ***************************************************************
   // Decoded outputs, registered
   // ***************************************************************
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cal_reference_o        <= APTR_REF_5V0;
         margining_enable_o     <= 1'b0;
         margining_trim_steps_o <= '0;
      end else begin
         cal_reference_o        <= aptr_ref_decode(cal_sel_ff);
         margining_enable_o     <= margining_enable_ff;
         // Trim only applied while margining is on
         margining_trim_steps_o <= margining_enable_ff ?
                                   aptr_trim_steps(margining_trim_code_ff) : '0;
      end
   end

   // ***************************************************************
   // Pattern assembly and word mux
   // ***************************************************************
   assign pattern = {pattern_top_nibble_ff, pattern_middle_byte_ff,
                     pattern_low_byte_ff[7 -: LOW_USED_W]};

   aptr_word_mux u_word_mux (
      .core_clk_i              (core_clk_i),
      .rst_i                   (rst_i),
      .pattern_output_select_i (pattern_output_select_ff),
      .conv_result_i           (conv_result_i),
      .pattern_i               (pattern),
      .out_word_o              (out_word_o)
   );

   // ***************************************************************
   // APB read path, zero wait states
   // ***************************************************************
   always_comb begin
      rd_byte = RST_BYTE;
      unique case (idx)
         IDX_PATN_TOP:   rd_byte = {4'h0, pattern_top_nibble_ff};
         IDX_PATN_MID:   rd_byte = pattern_middle_byte_ff;
         IDX_PATN_LOW:   rd_byte = pattern_low_byte_ff;
         IDX_DATA_CTRL:  rd_byte = {7'h00, pattern_output_select_ff};
         IDX_CAL_REF:    rd_byte = {5'h00, cal_sel_ff};
         IDX_REF_MARGIN: rd_byte = {2'h0, margining_enable_ff, margining_trim_code_ff};
         default:        rd_byte = RST_BYTE;
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         prdata  <= (psel & ~penable & ~pwrite & hit) ? {24'h0000_00, rd_byte} : '0;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   chk_top_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (wr_en && hit && idx == IDX_PATN_TOP) |=> pattern_top_nibble_ff == $past(pwdata[3:0]))
      else $error("top nibble not written");

   chk_top_reserved: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (rd_en && pready && $past(idx) == IDX_PATN_TOP) |-> prdata[31:4] == '0)
      else $error("top reserved bits nonzero");

   chk_cal_reserved: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (rd_en && pready && $past(idx) == IDX_CAL_REF) |-> prdata[31:3] == '0)
      else $error("cal reserved bits nonzero");

   chk_marg_reserved: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (rd_en && pready && $past(idx) == IDX_REF_MARGIN) |-> prdata[31:6] == '0)
      else $error("margin reserved bits nonzero");

   chk_ref_alias: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cal_sel_ff > 3'h5) |=> cal_reference_o == APTR_REF_5V0)
      else $error("high cal code not 5.0 V");

   chk_marg_enable: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (wr_en && hit && idx == IDX_REF_MARGIN) |=> ##1 margining_enable_o == $past(pwdata[5], 2))
      else $error("margining enable not applied");

   chk_trim_sign: assert property (@(posedge core_clk_i) disable iff (rst_i)
      margining_enable_ff |=> (margining_trim_steps_o < 0) == $past(margining_trim_code_ff[4]))
      else $error("trim sign wrong");

   chk_mid_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (wr_en && hit && idx == IDX_PATN_MID) |=> pattern_middle_byte_ff == $past(pwdata[7:0]))
      else $error("middle byte not written");

   chk_pattern_top: assert property (@(posedge core_clk_i) disable iff (rst_i)
      pattern_output_select_ff && $stable(pattern_top_nibble_ff) |=>
      out_word_o[21:18] == $past(pattern_top_nibble_ff))
      else $error("pattern top not in word");

   chk_select_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !rst_i && !pattern_output_select_ff |=> out_word_o[21:4] == $past(conv_result_i))
      else $error("pattern leaked to word");

endmodule // aptr_regs

// ### hdl/aptr_word_mux.sv
/*
 * Output word data field mux: conversion result or fixed pattern.
 * Assumes result and pattern are synchronous to core_clk_i.
 */
`timescale 1ns/1ps
module aptr_word_mux
   import aptr_pkg::*;
(
   // Clock and reset
   input  wire logic               core_clk_i,
   input  wire logic               rst_i,
   // Sources
   input  wire logic               pattern_output_select_i,
   input  wire logic [PAT_W-1:0]   conv_result_i,
   input  wire logic [PAT_W-1:0]   pattern_i,
   // Word
   output logic      [WORD_W-1:0]  out_word_o
);

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_word_o <= '0;
      end else begin
         out_word_o <= '0;
         out_word_o[WORD_LSB +: PAT_W] <= pattern_output_select_i ? pattern_i : conv_result_i;
      end
   end

   // Edge after reset release shows the cleared word, not the mux
   chk_mux_source: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !$past(rst_i) |->
      out_word_o[WORD_LSB +: PAT_W] == ($past(pattern_output_select_i) ? $past(pattern_i)
                                                                        : $past(conv_result_i)))
      else $error("word field source wrong");

endmodule // aptr_word_mux

// ### include/aptr_pkg.sv
/*
 * Package for the pattern and reference trim register bank:
 * register indices, field positions, reset values, decode constants.
 * Assumes an APB slave with 32-bit data, one register per word.
 */
package aptr_pkg;

   // ***************************************************************
   // Register indices, byte address is index * 4
   // ***************************************************************
   localparam logic [7:0]  IDX_PATN_LOW    = 8'h14;
   localparam logic [7:0]  IDX_PATN_MID    = 8'h15;
   localparam logic [7:0]  IDX_PATN_TOP    = 8'h16;
   localparam logic [7:0]  IDX_CAL_REF     = 8'h20;
   localparam logic [7:0]  IDX_REF_MARGIN  = 8'h30;
   localparam logic [7:0]  IDX_DATA_CTRL   = 8'h10;
   localparam int          ADDR_W          = 12;
   localparam int          BYTE_SHIFT      = 2;

   // ***************************************************************
   // Field layout
   // ***************************************************************
   localparam int          TOP_W           = 4;
   localparam int          CAL_W           = 3;
   localparam int          TRIM_W          = 5;
   localparam int          MARG_EN_BIT     = 5;
   localparam int          PSEL_BIT        = 0;
   localparam int          PAT_W           = 18;
   localparam int          LOW_USED_W      = 6;
   localparam int          WORD_W          = 22;
   localparam int          WORD_LSB        = 4;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [7:0]  RST_BYTE        = 8'h00;
   localparam logic [3:0]  RST_TOP         = 4'h0;
   localparam logic [2:0]  RST_CAL         = 3'h0;
   localparam logic [4:0]  RST_TRIM        = 5'h00;

   // ***************************************************************
   // Calibration reference selection
   // ***************************************************************
   typedef enum logic [2:0] {
      APTR_REF_5V0   = 3'h0,
      APTR_REF_4V5   = 3'h1,
      APTR_REF_4V096 = 3'h2,
      APTR_REF_3V3   = 3'h3,
      APTR_REF_3V0   = 3'h4,
      APTR_REF_2V5   = 3'h5
   } aptr_ref_t;

   // Signed trim step code: 0..15 positive, -16..-1 negative
   function automatic logic signed [TRIM_W-1:0] aptr_trim_steps(input logic [TRIM_W-1:0] c);
      return $signed(c);
   endfunction

   function automatic aptr_ref_t aptr_ref_decode(input logic [CAL_W-1:0] c);
      aptr_ref_t r;
      r = APTR_REF_5V0;
      if (c <= 3'h5) begin
         r = aptr_ref_t'(c);
      end
      return r;
   endfunction

endpackage

// ### tb/adc_pattern_and_ref_trim_regs_tb.sv
/*
 * Self-checking bench for the pattern and reference trim register bank.
 * Assumes the host model drives APB; expectations come from bench functions.
 */
`timescale 1ns/1ps
module adc_pattern_and_ref_trim_regs_tb
   import aptr_pkg::*;
;
   logic core_clk_i = 1'b0, rst_i = 1'b1;
   logic psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [PAT_W-1:0] conv_result_i = '0;
   logic [WORD_W-1:0] out_word_o;
   aptr_ref_t cal_reference_o;
   logic margining_enable_o, err;
   logic signed [TRIM_W-1:0] margining_trim_steps_o;
   logic [7:0] top, mid, low, mrg;
   int n_fail = 0, check_count = 0, seed = 53;

   always #5 core_clk_i = ~core_clk_i;

   aptr_host host_u (.core_clk_i(core_clk_i), .psel_o(psel), .penable_o(penable),
      .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb),
      .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
   aptr_regs dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_result_i(conv_result_i),
      .out_word_o(out_word_o), .cal_reference_o(cal_reference_o),
      .margining_enable_o(margining_enable_o),
      .margining_trim_steps_o(margining_trim_steps_o));

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [ADDR_W-1:0] ba(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction
   function automatic logic [2:0] exp_ref(input logic [2:0] c);
      return (c > 3'h5) ? 3'h0 : c;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      host_u.xfer(1'b1, ba(i), d, 4'hf, rd, err);
   endtask
   task automatic rdchk(input logic [7:0] i, input logic [31:0] exp);
      host_u.xfer(1'b0, ba(i), 32'h0000_0000, 4'h0, rd, err);
      chk({rd[31:1], err}, {exp[31:1], 1'b0} | {31'h0000_0000, 1'b0});
      chk(rd, exp);
   endtask
   // Outputs are looked at away from the edge that launches them
   task automatic settle;
      repeat (3) @(posedge core_clk_i);
      @(negedge core_clk_i);
   endtask
   task automatic complete_run;
      if (n_fail == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   initial begin
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(negedge core_clk_i);
      chk({10'h000, out_word_o}, 32'h0000_0000);
      chk({28'h000_0000, margining_enable_o, cal_reference_o}, 32'h0000_0000);
      rdchk(IDX_PATN_TOP, 32'h0000_0000);
      rdchk(IDX_CAL_REF, 32'h0000_0000);
      rdchk(IDX_REF_MARGIN, 32'h0000_0000);
      // Reserved bits read back zero
      wr(IDX_PATN_TOP, 32'hffff_ffff);
      rdchk(IDX_PATN_TOP, 32'h0000_000f);
      wr(IDX_CAL_REF, 32'hffff_ffff);
      rdchk(IDX_CAL_REF, 32'h0000_0007);
      wr(IDX_REF_MARGIN, 32'hffff_ffff);
      rdchk(IDX_REF_MARGIN, 32'h0000_003f);
      // Disabled strobe leaves the register alone
      host_u.xfer(1'b1, ba(IDX_PATN_TOP), 32'h0000_0005, 4'h0, rd, err);
      rdchk(IDX_PATN_TOP, 32'h0000_000f);
      // Unmapped and unaligned places answer with an error
      host_u.xfer(1'b0, ba(8'h11), 32'h0000_0000, 4'h0, rd, err);
      chk({rd[30:0], err}, 32'h0000_0001);
      host_u.xfer(1'b0, ba(IDX_PATN_TOP) + 12'h001, 32'h0000_0000, 4'h0, rd, err);
      chk({31'h0000_0000, err}, 32'h0000_0001);
      for (int c = 0; c < 8; c++) begin
         wr(IDX_CAL_REF, 32'(c));
         settle();
         chk({29'h0000_0000, cal_reference_o}, {29'h0000_0000, exp_ref(3'(c))});
      end
      // Margining: corners first, then random codes
      for (int k = 0; k < 12; k++) begin
         mrg = (k == 0) ? 8'h2f : (k == 1) ? 8'h30 : (k == 2) ? 8'h1f : 8'($random(seed));
         wr(IDX_REF_MARGIN, {24'h00_0000, mrg});
         settle();
         chk({31'h0000_0000, margining_enable_o}, {31'h0000_0000, mrg[5]});
         chk({27'h0, margining_trim_steps_o}, {27'h0, mrg[5] ? mrg[4:0] : 5'h00});
      end
      // Pattern versus conversion result on the output word
      for (int k = 0; k < 8; k++) begin
         top = 8'($random(seed));
         mid = 8'($random(seed));
         low = 8'($random(seed));
         wr(IDX_PATN_TOP, {24'h00_0000, top});
         conv_result_i <= PAT_W'($random(seed));
         wr(IDX_PATN_MID, {24'h00_0000, mid});
         wr(IDX_PATN_LOW, {24'h00_0000, low});
         wr(IDX_DATA_CTRL, 32'(k % 2));
         rdchk(IDX_PATN_MID, {24'h00_0000, mid});
         settle();
         if (k % 2 == 0)
            chk({10'h000, out_word_o}, {10'h000, conv_result_i, 4'h0});
         else
            chk({10'h000, out_word_o}, {10'h000, top[3:0], mid, low[7:2], 4'h0});
      end
      // Mid-run reset clears what was written, result returns to the word
      rst_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      rdchk(IDX_PATN_TOP, 32'h0000_0000);
      rdchk(IDX_CAL_REF, 32'h0000_0000);
      rdchk(IDX_REF_MARGIN, 32'h0000_0000);
      settle();
      chk({10'h000, out_word_o}, {10'h000, conv_result_i, 4'h0});
      complete_run();
   end

   initial begin
      #200000;
      n_fail++;
      complete_run();
   end
endmodule // adc_pattern_and_ref_trim_regs_tb

// ### tb/aptr_host.sv
/*
 * Host controller model: APB master that reaches the register bank.
 * Assumes a zero or longer wait slave on core_clk_i, 12-bit byte address.
 */
`timescale 1ns/1ps
module aptr_host
   import aptr_pkg::*;
(
   // Clock
   input  wire logic               core_clk_i,
   // APB master
   output logic                    psel_o,
   output logic                    penable_o,
   output logic                    pwrite_o,
   output logic      [ADDR_W-1:0]  paddr_o,
   output logic      [31:0]        pwdata_o,
   output logic      [3:0]         pstrb_o,
   input  wire logic [31:0]        prdata_i,
   input  wire logic               pready_i,
   input  wire logic               pslverr_i
);
   initial begin
      psel_o    = 1'b0;
      penable_o = 1'b0;
      pwrite_o  = 1'b0;
      paddr_o   = '0;
      pwdata_o  = '0;
      pstrb_o   = 4'h0;
   end

   // One transfer; waits on pready without assuming a latency, bench watchdog ends a hang
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                       input logic [3:0] st, output logic [31:0] rd, output logic err);
      @(posedge core_clk_i);
      psel_o    <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o  <= wr;
      paddr_o   <= a;
      pwdata_o  <= wd;
      pstrb_o   <= st;
      @(posedge core_clk_i);
      penable_o <= 1'b1;
      do begin
         @(posedge core_clk_i);
      end while (pready_i !== 1'b1);
      rd = prdata_i;
      err = pslverr_i;
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      // Released lines must not keep showing the last value
      paddr_o   <= ~a;
      pwdata_o  <= ~wd;
   endtask
endmodule // aptr_host
